// [tcm_pkg.sv]
package tcm_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int unsigned NUM_MODULES  = 6;
    localparam int unsigned NUM_COUNTERS = 2;
    localparam int unsigned CNT_W        = 16;
    localparam int unsigned ADDR_W       = 8;
    localparam int unsigned DATA_W       = 32;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] MODE_CFG_BASE   = 8'h00;  // Six words, 0x00..0x14
    localparam logic [ADDR_W-1:0] STATUS_OFFS     = 8'h18;
    localparam logic [ADDR_W-1:0] IRQ_MASK_OFFS   = 8'h1c;
    localparam logic [ADDR_W-1:0] CTRL_OFFS       = 8'h20;
    localparam logic [ADDR_W-1:0] FLAG_SET_OFFS   = 8'h24;

    // ------------------------------------------------------------------
    // Mode register fields
    // ------------------------------------------------------------------
    localparam int unsigned MODE_IRQ_EN_BIT   = 7;
    localparam int unsigned MODE_COMP_EN_BIT  = 6;
    localparam int unsigned MODE_CAP_RISE_BIT = 5;
    localparam int unsigned MODE_CAP_FALL_BIT = 4;
    localparam int unsigned MODE_MATCH_BIT    = 3;
    localparam int unsigned MODE_TOGGLE_BIT   = 2;
    localparam int unsigned MODE_PWM_HI       = 1;
    localparam int unsigned MODE_PWM_LO       = 0;
    localparam logic [7:0]  MODE_RESET        = 8'h00;

    // PWM field encodings
    localparam logic [1:0] PWM_OFF        = 2'h0;
    localparam logic [1:0] PWM_FIXED8     = 2'h1;
    localparam logic [1:0] PWM_PROG8      = 2'h2;
    localparam logic [1:0] PWM_FIXED_WIDE = 2'h3;

    // ------------------------------------------------------------------
    // Status / mask layout: module flags and overflow flags interleaved
    // ------------------------------------------------------------------
    localparam int unsigned STAT_OVF0_BIT = 3;
    localparam int unsigned STAT_OVF1_BIT = 7;
    localparam logic [7:0]  STATUS_RESET  = 8'h00;
    localparam logic [7:0]  MASK_RESET    = 8'hff;
    localparam logic [7:0]  OVF_BITS      = 8'h88;

    // Control register fields, one nibble per counter
    localparam int unsigned CTRL_OVF_IRQ_EN_BIT = 0;
    localparam int unsigned CTRL_TEN_BIT_BIT    = 1;
    localparam int unsigned CTRL_STRIDE         = 4;
    localparam logic [7:0]  CTRL_RESET          = 8'h00;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Decoded PWM function of a module
    typedef enum logic [2:0] {
        TCM_PWM_NONE    = 3'b000,
        TCM_PWM_FIXED8  = 3'b001,
        TCM_PWM_PROG8   = 3'b010,
        TCM_PWM_FIXED10 = 3'b011,
        TCM_PWM_FIXED16 = 3'b100
    } tcm_pwm_kind_t;

endpackage : tcm_pkg

// [tcm_mode_irq_merge.sv]
`timescale 1ns/100ps
`default_nettype none

module tcm_mode_irq_merge
    import tcm_pkg::*;
(
    // Clock and reset
    input  wire logic                               aclk,
    input  wire logic                               aresetn,
    // AXI4-Lite write address
    input  wire logic [ADDR_W-1:0]                  s_axi_awaddr,
    input  wire logic                               s_axi_awvalid,
    output logic                                    s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [DATA_W-1:0]                  s_axi_wdata,
    input  wire logic [DATA_W/8-1:0]                s_axi_wstrb,
    input  wire logic                               s_axi_wvalid,
    output logic                                    s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                              s_axi_bresp,
    output logic                                    s_axi_bvalid,
    input  wire logic                               s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [ADDR_W-1:0]                  s_axi_araddr,
    input  wire logic                               s_axi_arvalid,
    output logic                                    s_axi_arready,
    // AXI4-Lite read data
    output logic [DATA_W-1:0]                       s_axi_rdata,
    output logic [1:0]                              s_axi_rresp,
    output logic                                    s_axi_rvalid,
    input  wire logic                               s_axi_rready,
    // Counter array values and rollover pulses
    input  wire logic [NUM_COUNTERS-1:0][CNT_W-1:0] counter_value,
    input  wire logic [NUM_COUNTERS-1:0]            counter_rollover,
    // Per-module compare values and PWM waveform from the PWM engines
    input  wire logic [NUM_MODULES-1:0][CNT_W-1:0]  module_compare_value,
    input  wire logic [NUM_MODULES-1:0]             module_pwm_level,
    // Module pins
    input  wire logic [NUM_MODULES-1:0]             module_io_pin_in,
    output logic [NUM_MODULES-1:0]                  module_io_pin_out,
    output logic [NUM_MODULES-1:0]                  module_io_pin_oe,
    // Capture results and decoded PWM kind
    output logic [NUM_MODULES-1:0][CNT_W-1:0]       module_capture_value,
    output tcm_pwm_kind_t [NUM_MODULES-1:0]         module_pwm_kind,
    // Merged interrupt
    output logic                                    counter_array_irq
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------

    // Word index of a byte address (drops the two lane bits)
    function automatic logic [ADDR_W-3:0] word_index(input logic [ADDR_W-1:0] addr);
        word_index = addr[ADDR_W-1:2];
    endfunction : word_index

    // Status bit position of a module flag
    function automatic int unsigned flag_pos(input int unsigned m);
        flag_pos = (m < 3) ? m : m + 1;
    endfunction : flag_pos

    // Counter that serves a module: modules 0..2 on counter 0, 3..5 on counter 1
    function automatic int unsigned counter_of(input int unsigned m);
        counter_of = (m < 3) ? 0 : 1;
    endfunction : counter_of

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [NUM_MODULES-1:0][7:0] mode_cfg_reg;
    logic [7:0]                  status_reg;
    logic [7:0]                  irq_mask_reg;
    logic [7:0]                  ctrl_reg;
    logic [NUM_MODULES-1:0]      pin_prev_reg;
    logic [NUM_MODULES-1:0]      toggle_out_reg;
    logic [NUM_MODULES-1:0][CNT_W-1:0] capture_reg;
    logic                        irq_reg;

    // AXI holding state
    logic                        aw_held_reg;
    logic [ADDR_W-1:0]           aw_addr_reg;
    logic                        w_held_reg;
    logic [DATA_W-1:0]           w_data_reg;
    logic                        w_strb0_reg;
    logic                        bvalid_reg;
    logic [1:0]                  bresp_reg;
    logic                        rvalid_reg;
    logic [1:0]                  rresp_reg;
    logic [DATA_W-1:0]           rdata_reg;

    // Write strobes decoded from the committed write
    logic                        wr_fire;
    logic [ADDR_W-3:0]           wr_idx;
    logic                        wr_hit;
    logic [7:0]                  wr_byte;
    logic [7:0]                  status_clr;
    logic [7:0]                  status_set;
    logic [7:0]                  status_next;
    logic [7:0]                  irq_gate;

    // ------------------------------------------------------------------
    // AXI4-Lite write channels
    // ------------------------------------------------------------------

    // Address and data are taken in either order; no new ones while a response waits
    assign s_axi_awready = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready  = !w_held_reg && !bvalid_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;

    // Write address holding
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= '0;
        end else if (wr_fire) begin
            aw_held_reg <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
        end
    end

    // Write data holding; only the low lane carries register bits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_reg  <= 1'b0;
            w_data_reg  <= '0;
            w_strb0_reg <= 1'b0;
        end else if (wr_fire) begin
            w_held_reg <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg  <= 1'b1;
            w_data_reg  <= s_axi_wdata;
            w_strb0_reg <= s_axi_wstrb[0];
        end
    end

    // Commit once both halves are held
    assign wr_fire = aw_held_reg && w_held_reg;
    assign wr_idx  = word_index(aw_addr_reg);
    assign wr_byte = w_data_reg[7:0];
    assign wr_hit  = (wr_idx < word_index(MODE_CFG_BASE) + NUM_MODULES[ADDR_W-3:0])
                  || (wr_idx == word_index(STATUS_OFFS))
                  || (wr_idx == word_index(IRQ_MASK_OFFS))
                  || (wr_idx == word_index(CTRL_OFFS))
                  || (wr_idx == word_index(FLAG_SET_OFFS));

    // Write response, unmapped addresses answer SLVERR
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Software-written registers
    // ------------------------------------------------------------------

    // Mode registers; zero means the module does nothing
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_cfg_reg <= {NUM_MODULES{MODE_RESET}};
        end else if (wr_fire && w_strb0_reg
                     && wr_idx < word_index(MODE_CFG_BASE) + NUM_MODULES[ADDR_W-3:0]) begin
            mode_cfg_reg[wr_idx[2:0]] <= wr_byte;
        end
    end

    // Interrupt mask and counter control
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_mask_reg <= MASK_RESET;
            ctrl_reg     <= CTRL_RESET;
        end else if (wr_fire && w_strb0_reg) begin
            if (wr_idx == word_index(IRQ_MASK_OFFS)) begin
                irq_mask_reg <= wr_byte;
            end
            if (wr_idx == word_index(CTRL_OFFS)) begin
                ctrl_reg <= wr_byte;
            end
        end
    end

    // ------------------------------------------------------------------
    // Per-module capture, compare and pin logic
    // ------------------------------------------------------------------
    logic [NUM_MODULES-1:0] module_event;

    // Pin history for edge detection; inputs are already synchronous
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_prev_reg <= '0;
        end else begin
            pin_prev_reg <= module_io_pin_in;
        end
    end

    generate
        for (genvar m = 0; m < NUM_MODULES; m++) begin : g_module
            localparam int unsigned CNT = counter_of(m);
            logic [7:0] mode;
            logic       rise;
            logic       fall;
            logic       match;
            logic       capture;
            logic       pwm_on;
            logic       wide10;

            assign mode = mode_cfg_reg[m];
            assign rise = module_io_pin_in[m] && !pin_prev_reg[m];
            assign fall = !module_io_pin_in[m] && pin_prev_reg[m];
            // Comparator is live only with its enable bit
            assign match = mode[MODE_COMP_EN_BIT]
                        && (counter_value[CNT] == module_compare_value[m]);
            // Either edge bit, or both for transition capture
            assign capture = (mode[MODE_CAP_RISE_BIT] && rise)
                          || (mode[MODE_CAP_FALL_BIT] && fall);
            assign module_event[m] = capture
                                  || (match && mode[MODE_MATCH_BIT]);

            // Full 16-bit counter snapshot on a capture edge
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    capture_reg[m] <= '0;
                end else if (capture) begin
                    capture_reg[m] <= counter_value[CNT];
                end
            end

            // Toggle output flips on every match while toggle is selected
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    toggle_out_reg[m] <= 1'b0;
                end else if (match && mode[MODE_TOGGLE_BIT]) begin
                    toggle_out_reg[m] <= !toggle_out_reg[m];
                end
            end

            // PWM kind; the wide setting follows the counter's ten-bit select
            assign pwm_on = (mode[MODE_PWM_HI:MODE_PWM_LO] != PWM_OFF);
            assign wide10 = ctrl_reg[CNT*CTRL_STRIDE + CTRL_TEN_BIT_BIT];
            always_comb begin
                case (mode[MODE_PWM_HI:MODE_PWM_LO])
                    PWM_FIXED8:     module_pwm_kind[m] = TCM_PWM_FIXED8;
                    PWM_PROG8:      module_pwm_kind[m] = TCM_PWM_PROG8;
                    PWM_FIXED_WIDE: module_pwm_kind[m] = wide10 ? TCM_PWM_FIXED10
                                                                : TCM_PWM_FIXED16;
                    default:        module_pwm_kind[m] = TCM_PWM_NONE;
                endcase
            end

            // PWM takes the pin over toggle; pin is released with neither
            assign module_io_pin_out[m] = pwm_on ? module_pwm_level[m]
                                                 : toggle_out_reg[m];
            assign module_io_pin_oe[m]  = pwm_on || mode[MODE_TOGGLE_BIT];
        end
    endgenerate

    assign module_capture_value = capture_reg;

    // ------------------------------------------------------------------
    // Status flags and interrupt merge
    // ------------------------------------------------------------------

    // Set terms from hardware events and from the software set register
    always_comb begin
        status_set = '0;
        for (int unsigned m = 0; m < NUM_MODULES; m++) begin
            status_set[flag_pos(m)] = module_event[m];
        end
        status_set[STAT_OVF0_BIT] = counter_rollover[0];
        status_set[STAT_OVF1_BIT] = counter_rollover[1];
        if (wr_fire && w_strb0_reg && wr_idx == word_index(FLAG_SET_OFFS)) begin
            status_set = status_set | (wr_byte & OVF_BITS);
        end
    end

    // Write-one-to-clear; a set in the same cycle wins
    assign status_clr  = (wr_fire && w_strb0_reg && wr_idx == word_index(STATUS_OFFS))
                       ? wr_byte : 8'h00;
    assign status_next = (status_reg & ~status_clr) | status_set;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_reg <= STATUS_RESET;
        end else begin
            status_reg <= status_next;
        end
    end

    // Per-source enables: mode bit 7 for modules, overflow enable for counters
    always_comb begin
        irq_gate = '0;
        for (int unsigned m = 0; m < NUM_MODULES; m++) begin
            irq_gate[flag_pos(m)] = mode_cfg_reg[m][MODE_IRQ_EN_BIT];
        end
        irq_gate[STAT_OVF0_BIT] = ctrl_reg[CTRL_OVF_IRQ_EN_BIT];
        irq_gate[STAT_OVF1_BIT] = ctrl_reg[CTRL_STRIDE + CTRL_OVF_IRQ_EN_BIT];
    end

    // All eight sources ORed; level follows the flags for as long as they stand
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(status_next & irq_gate & irq_mask_reg);
        end
    end
    assign counter_array_irq = irq_reg;

    // ------------------------------------------------------------------
    // AXI4-Lite read channels
    // ------------------------------------------------------------------
    logic [ADDR_W-3:0] rd_idx;
    logic [7:0]        rd_byte;
    logic              rd_hit;

    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;
    assign rd_idx        = word_index(s_axi_araddr);

    // Read decode; status shows all flags so the handler can pick its sources
    always_comb begin
        rd_byte = 8'h00;
        rd_hit  = 1'b1;
        if (rd_idx < word_index(MODE_CFG_BASE) + NUM_MODULES[ADDR_W-3:0]) begin
            rd_byte = mode_cfg_reg[rd_idx[2:0]];
        end else if (rd_idx == word_index(STATUS_OFFS)) begin
            rd_byte = status_reg;
        end else if (rd_idx == word_index(IRQ_MASK_OFFS)) begin
            rd_byte = irq_mask_reg;
        end else if (rd_idx == word_index(CTRL_OFFS)) begin
            rd_byte = ctrl_reg;
        end else if (rd_idx == word_index(FLAG_SET_OFFS)) begin
            rd_byte = 8'h00;                                                  // Write-only
        end else begin
            rd_hit = 1'b0;
        end
    end

    // Read response one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rresp_reg  <= RESP_OKAY;
            rdata_reg  <= '0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_reg <= 1'b1;
            rresp_reg  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            rdata_reg  <= {{(DATA_W-8){1'b0}}, rd_byte};
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

endmodule : tcm_mode_irq_merge

`default_nettype wire

// [tcm_irq_monitor.sv]
`timescale 1ns/100ps
`default_nettype none
module tcm_irq_monitor
    import tcm_pkg::*;
(
    // Clock and reset
    input wire logic                                aclk,
    input wire logic                                aresetn,
    // Bus handshakes
    input wire logic                                s_axi_awvalid,
    input wire logic                                s_axi_awready,
    input wire logic                                s_axi_wvalid,
    input wire logic                                s_axi_wready,
    input wire logic                                s_axi_bvalid,
    input wire logic                                s_axi_arvalid,
    input wire logic                                s_axi_arready,
    input wire logic                                s_axi_rvalid,
    // Counters, pins and results
    input wire logic [NUM_COUNTERS-1:0][CNT_W-1:0]  counter_value,
    input wire logic [NUM_MODULES-1:0]              module_pwm_level,
    input wire logic [NUM_MODULES-1:0]              module_io_pin_in,
    input wire logic [NUM_MODULES-1:0]              module_io_pin_out,
    input wire logic [NUM_MODULES-1:0]              module_io_pin_oe,
    input wire logic [NUM_MODULES-1:0][CNT_W-1:0]   module_capture_value,
    input wire tcm_pwm_kind_t [NUM_MODULES-1:0]     module_pwm_kind,
    input wire logic                                counter_array_irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ------------------------------------------------------------------
    // Sequences
    // ------------------------------------------------------------------
    sequence wr_taken_s;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // Registered irq may lag the commit by one edge, so both edges are allowed
    sequence commit_s;
        $rose(s_axi_bvalid) || $fell(s_axi_bvalid);
    endsequence
    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    rst_quiet_a: assert property ($rose(aresetn) |-> !counter_array_irq && module_io_pin_oe == 6'h00)
        else $error("outputs not quiet after reset");
    wr_resp_a: assert property (wr_taken_s |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    rd_ans_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    irq_fall_a: assert property ($fell(counter_array_irq) |-> commit_s)
        else $error("irq dropped without software write");
    mode_write_a: assert property ($changed(module_io_pin_oe) || $changed(module_pwm_kind) |-> $rose(s_axi_bvalid))
        else $error("pin mode changed without register write");
    // Per-module pin and capture relations
    for (genvar m = 0; m < 6; m++) begin : g_mod
        pwm_pin_a: assert property (module_pwm_kind[m] != TCM_PWM_NONE |-> module_io_pin_oe[m] && module_io_pin_out[m] == module_pwm_level[m])
            else $error("pwm level not on pin");
        cap_src_a: assert property ($changed(module_capture_value[m]) |-> $past(module_io_pin_in[m]) != $past(module_io_pin_in[m], 2))
            else $error("capture without pin edge");
        cap_val_a: assert property ($changed(module_capture_value[m]) |-> module_capture_value[m] == $past(counter_value[m/3]))
            else $error("capture value wrong");
    end
endmodule : tcm_irq_monitor
bind tcm_mode_irq_merge tcm_irq_monitor u_mon (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .counter_value, .module_pwm_level, .module_io_pin_in, .module_io_pin_out, .module_io_pin_oe,
    .module_capture_value, .module_pwm_kind, .counter_array_irq);
`default_nettype wire

// [test_tcm_mode_irq_merge.sv]
`timescale 1ns/100ps
`default_nettype none
module test_tcm_mode_irq_merge
    import tcm_pkg::*;
;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, counter_array_irq;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp, counter_rollover = 2'h0;
    logic [1:0][15:0] counter_value = 32'h0;
    logic [5:0][15:0] module_compare_value = {{5{16'hffff}}, 16'h0005}, module_capture_value;
    logic [5:0] module_pwm_level = 6'h0, module_io_pin_in = 6'h0, module_io_pin_out, module_io_pin_oe;
    tcm_pwm_kind_t [5:0] module_pwm_kind;
    int fail_count = 0, compares = 0;
    always #25 aclk = ~aclk;
    tcm_mode_irq_merge u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .counter_value, .counter_rollover, .module_compare_value,
        .module_pwm_level, .module_io_pin_in, .module_io_pin_out, .module_io_pin_oe,
        .module_capture_value, .module_pwm_kind, .counter_array_irq);
    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic end_sim;
        $display("Compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : end_sim
    // Write: both halves offered together, bready held until the answer; returns
    // at the next falling edge, so an irq that lags a config write has settled
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
        logic ad, dd, ta, tw, b;
        logic [1:0] rs;
        ad = 0;
        dd = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int n = 0; n < 40; n++) begin
            @(negedge aclk);
            ta = s_axi_awready & ~ad;
            tw = s_axi_wready & ~dd;
            b = s_axi_bvalid;
            rs = s_axi_bresp;
            @(posedge aclk);
            if (ta) begin ad = 1; s_axi_awvalid <= 1'b0; end
            if (tw) begin dd = 1; s_axi_wvalid <= 1'b0; end
            if (b) begin s_axi_bready <= 1'b0; chk("bresp", er, rs); @(negedge aclk); return; end
        end
        fail_count++;
        end_sim();
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = RESP_OKAY);
        logic ad, ta, b;
        logic [31:0] dt;
        logic [1:0] rs;
        ad = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int n = 0; n < 40; n++) begin
            @(negedge aclk);
            ta = s_axi_arready & ~ad;
            b = s_axi_rvalid;
            dt = s_axi_rdata;
            rs = s_axi_rresp;
            @(posedge aclk);
            if (ta) begin ad = 1; s_axi_arvalid <= 1'b0; end
            if (b) begin s_axi_rready <= 1'b0; chk($sformatf("rd %h", a), e, dt); chk("rresp", er, rs); return; end
        end
        fail_count++;
        end_sim();
    endtask : rd
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        for (int m = 0; m < 6; m++) rd(8'(4 * m), 32'h0);
        rd(IRQ_MASK_OFFS, 32'hff);
        rd(8'h40, 32'h0, RESP_SLVERR);
        @(negedge aclk);
        chk("irq", 0, counter_array_irq);
    endtask : t_reset
    task automatic t_ovf;
        @(posedge aclk);
        counter_rollover <= 2'h1;
        @(posedge aclk);
        counter_rollover <= 2'h0;
        @(negedge aclk);
        chk("irq", 0, counter_array_irq);
        rd(STATUS_OFFS, 32'h08);
        wr(CTRL_OFFS, 8'h01);
        chk("irq", 1, counter_array_irq);
        wr(IRQ_MASK_OFFS, 8'hf7);
        chk("irq", 0, counter_array_irq);
        wr(IRQ_MASK_OFFS, 8'hff);
        wr(STATUS_OFFS, 8'h08);
        chk("irq", 0, counter_array_irq);
        wr(FLAG_SET_OFFS, 8'h80);
        wr(CTRL_OFFS, 8'h10);
        chk("irq", 1, counter_array_irq);
        wr(STATUS_OFFS, 8'h80);
        rd(STATUS_OFFS, 32'h0);
    endtask : t_ovf
    // Without the comparator enable a match must do nothing
    task automatic t_match;
        for (int k = 0; k < 2; k++) begin
            wr(MODE_CFG_BASE, k ? 8'h4c : 8'h0c);
            @(posedge aclk);
            counter_value[0] <= 16'h0005;
            @(posedge aclk);
            counter_value[0] <= 16'h0000;
            @(negedge aclk);
            chk("pin0", k, module_io_pin_out[0]);
            chk("irq", 0, counter_array_irq);
            rd(STATUS_OFFS, k);
        end
        wr(MODE_CFG_BASE, 8'hcc);
        chk("irq", 1, counter_array_irq);
        wr(STATUS_OFFS, 8'h01);
        chk("irq", 0, counter_array_irq);
    endtask : t_match
    task automatic t_cap;
        for (int k = 0; k < 6; k++) begin
            wr(8'h0c, k < 2 ? 8'h20 : (k < 4 ? 8'h10 : 8'h30));
            @(posedge aclk);
            counter_value[1] <= 16'h1000 + 16'(k);
            module_io_pin_in[3] <= (k % 2 == 0);
            @(posedge aclk);
            @(negedge aclk);
            chk("cap3", 32'h1000 + ((k == 1 || k == 2) ? 0 : k), module_capture_value[3]);
        end
        rd(STATUS_OFFS, 32'h10);
    endtask : t_cap
    task automatic t_pwm;
        tcm_pwm_kind_t ek[4] = '{TCM_PWM_FIXED8, TCM_PWM_PROG8, TCM_PWM_FIXED16, TCM_PWM_FIXED10};
        module_pwm_level <= 6'h02;
        for (int k = 0; k < 4; k++) begin
            if (k == 3) wr(CTRL_OFFS, 8'h02);
            wr(8'h04, 8'h40 | 8'(k > 2 ? 3 : k + 1));
            chk("kind1", ek[k], module_pwm_kind[1]);
            chk("pin1", 2'b11, {module_io_pin_oe[1], module_io_pin_out[1]});
        end
    endtask : t_pwm
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_ovf();
        t_match();
        t_cap();
        t_pwm();
        end_sim();
    end
endmodule : test_tcm_mode_irq_merge
`default_nettype wire
